// >>> common/output_clock_pin_core_pkg.sv
package output_clock_pin_core_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_CLOCK_OUTPUT_SELECT = 8'h07;
    localparam logic [7:0] ADDR_LDO_CONTROL         = 8'h08;
    localparam logic [7:0] ADDR_PROCESSOR_CONTROL   = 8'h09;

    localparam logic [7:0] RST_CLOCK_OUTPUT_SELECT  = 8'h00;
    localparam logic [7:0] RST_LDO_CONTROL          = 8'h00;
    localparam logic [7:0] RST_PROCESSOR_CONTROL    = 8'h04;
    localparam logic [7:0] UNMAPPED_READ            = 8'h00;

    // ==========================================================
    // Field positions
    localparam int RATE_SEL_LSB     = 0;  // clock_output_select[2:0]
    localparam int LDO_VSEL_LSB     = 0;  // ldo_control[1:0]
    localparam int LDO_PD_BIT       = 2;  // ldo_control[2]
    localparam int RUN_BIT          = 0;  // processor_control[0]
    localparam int SAMPLE_RATE_LSB  = 1;  // processor_control[2:1]
    localparam int SLOW_RATE_LSB    = 3;  // processor_control[4:3]
    localparam int BANK_SEL_LSB     = 5;  // processor_control[6:5]
    localparam int ZERO_STATE_BIT   = 7;  // processor_control[7]

    // ==========================================================
    // Field codes
    localparam logic [2:0] CLK_SEL_X2   = 3'h0;
    localparam logic [2:0] CLK_SEL_X1   = 3'h1;
    localparam logic [2:0] CLK_SEL_DIV2 = 3'h2;
    localparam logic [2:0] CLK_SEL_DIV4 = 3'h3;
    localparam logic [2:0] CLK_SEL_DIV8 = 3'h4;
    localparam logic [2:0] CLK_SEL_OFF  = 3'h7;

    localparam logic [1:0] LDO_V_1V2    = 2'h0;
    localparam logic [1:0] LDO_V_1V1    = 2'h1;
    localparam logic [1:0] BANK_A       = 2'h0;
    localparam logic [1:0] BANK_B       = 2'h1;
    localparam logic [1:0] SLOW_DIV1    = 2'h0;
    localparam logic [1:0] SLOW_DIV8    = 2'h2;
    localparam logic [1:0] FS_RESERVED  = 2'h0;
    localparam logic [1:0] FS_192K      = 2'h2;

    // ==========================================================
    // Register access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Effective processor settings
    typedef struct packed {
        logic       run;
        logic [1:0] sample_rate;
        logic [1:0] slow_rate;
        logic [1:0] bank;
    } core_cfg_t;

endpackage

// >>> tb/tb.sv
`timescale 1ns/1ps

module tb;
    import output_clock_pin_core_pkg::*;

    logic        i_ref_clk = 1'b0;
    logic        i_arst_n  = 1'b0;
    logic        clk_en    = 1'b1;
    reg_req_t    req       = '0;
    logic [7:0]  rdata;
    logic        mclk      = 1'b0;
    logic        mclk_x2   = 1'b0;
    logic        pin_mode  = 1'b1;
    logic        dens_on   = 1'b0;
    logic        prog_start = 1'b0;
    logic        pin;
    logic        ldo_pd;
    logic [1:0]  ldo_vsel;
    core_cfg_t   cfg;
    logic        st_clear;
    int          n_mismatch = 0;
    int          cmp_count  = 0;
    int          n_clear    = 0;
    int          seed       = 52;
    logic [7:0]  mdl [3];
    logic [1:0]  exp_vsel;
    logic [2:0]  mcnt = 3'h0;

    // ==========================================================
    // Clock, master clock stand-ins (period 8 and 4 cycles)
    always #5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        mcnt    <= mcnt + 3'h1;
        mclk    <= mcnt[2];
        mclk_x2 <= mcnt[1];
    end
    always @(posedge i_ref_clk) begin
        if (st_clear === 1'b1) n_clear <= n_clear + 1;
    end

    clock_out_and_core_control dut (
        .i_ref_clk             (i_ref_clk),
        .i_arst_n              (i_arst_n),
        .i_clk_en              (clk_en),
        .i_req                 (req),
        .o_rdata               (rdata),
        .i_master_clk          (mclk),
        .i_master_clk_x2       (mclk_x2),
        .i_output_clock_pin_pin_mode     (pin_mode),
        .i_density_mod_enabled (dens_on),
        .i_program_start       (prog_start),
        .o_output_clock_pin    (pin),
        .o_ldo_power_down      (ldo_pd),
        .o_ldo_voltage_sel     (ldo_vsel),
        .o_core_cfg            (cfg),
        .o_state_clear         (st_clear)
    );

    // ==========================================================
    // Shared tasks
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk) req <= '{1'b1, 1'b0, a, d};
        @(posedge i_ref_clk) req <= '0;
        if (clk_en && a >= 8'h07 && a <= 8'h09) mdl[a - 8'h07] = d;
    endtask
    // Read data lands one cycle after the request edge
    task automatic rd_chk(input logic [7:0] a);
        @(posedge i_ref_clk) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge i_ref_clk) req <= '0;
        #1 chk("rdata", (a >= 8'h07 && a <= 8'h09) ? mdl[a - 8'h07] : UNMAPPED_READ, rdata);
    endtask
    task automatic pulse_start();
        @(posedge i_ref_clk) prog_start <= 1'b1;
        @(posedge i_ref_clk) prog_start <= 1'b0;
    endtask
    // Rising edges of the pin over 256 cycles; tolerance of one for window phase
    task automatic pin_rate(input string name, input int exp);
        int n;
        logic prev;
        n = 0;
        repeat (100) @(posedge i_ref_clk);
        #1 prev = pin;
        repeat (256) begin
            @(posedge i_ref_clk);
            #1 if (pin === 1'b1 && prev !== 1'b1) n++;
            prev = pin;
        end
        cmp_count++;
        if (n < exp - 1 || n > exp + (exp > 0)) begin
            n_mismatch++;
            $display("[ERR] %s expected %0d seen %0d", name, exp, n);
        end
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ==========================================================
    // Watchdog, far beyond the few thousand cycles the tests need
    initial begin
        #400000;
        n_mismatch++;
        close_out();
    end

    // ==========================================================
    // Main sequence
    initial begin
        int rates [5] = '{64, 32, 16, 8, 4};
        logic [7:0] d;
        mdl = '{RST_CLOCK_OUTPUT_SELECT, RST_LDO_CONTROL, RST_PROCESSOR_CONTROL};
        exp_vsel = LDO_V_1V2;
        repeat (20) @(posedge i_ref_clk);
        i_arst_n <= 1'b1;
        // Reset values and unmapped reads
        for (int a = 7; a <= 10; a++) rd_chk(8'(a));
        chk("fs", {6'h0, FS_192K}, {6'h0, cfg.sample_rate});
        $display("test reset done");
        // Random register traffic, regulator outputs follow 0x08
        repeat (40) begin
            d = 8'($random(seed));
            wr(($random(seed) & 1) ? ADDR_LDO_CONTROL : 8'(8'h0a + (d & 8'h03)), d);
            if (mdl[1][1] == 1'b0) exp_vsel = mdl[1][1:0];
            repeat (2) @(posedge i_ref_clk);
            #1 chk("ldo_pd", {7'h0, mdl[1][2]}, {7'h0, ldo_pd});
            chk("ldo_vsel", {6'h0, exp_vsel}, {6'h0, ldo_vsel});
            rd_chk(ADDR_LDO_CONTROL);
            rd_chk(8'(8'h07 + (d & 8'h03)));
        end
        // Writes while frozen are dropped
        clk_en <= 1'b0;
        wr(ADDR_LDO_CONTROL, 8'hff);
        clk_en <= 1'b1;
        rd_chk(ADDR_LDO_CONTROL);
        $display("test registers done");
        // Output clock selections
        for (int c = 0; c < 5; c++) begin
            wr(ADDR_CLOCK_OUTPUT_SELECT, 8'(c));
            pin_rate("rate", rates[c]);
        end
        wr(ADDR_CLOCK_OUTPUT_SELECT, {5'h1f, CLK_SEL_OFF});
        pin_rate("off", 0);
        chk("pin_off", 8'h00, {7'h0, pin});
        wr(ADDR_CLOCK_OUTPUT_SELECT, {5'h00, CLK_SEL_DIV2});
        pin_mode <= 1'b0;
        pin_rate("mode", 0);
        pin_mode <= 1'b1;
        dens_on  <= 1'b1;
        pin_rate("dens_div2", 16);
        for (int c = 0; c < 2; c++) begin
            wr(ADDR_CLOCK_OUTPUT_SELECT, 8'(c));
            pin_rate("dens_fast", 0);
        end
        dens_on <= 1'b0;
        pin_rate("x1", 32);
        $display("test output clock done");
        // Rates apply while stopped; reserved codes hold
        wr(ADDR_PROCESSOR_CONTROL, 8'h0a);
        repeat (3) @(posedge i_ref_clk);
        #1 chk("cfg", 8'h14, {1'b0, cfg});
        wr(ADDR_PROCESSOR_CONTROL, 8'h18);
        repeat (3) @(posedge i_ref_clk);
        #1 chk("cfg_rsv", 8'h14, {1'b0, cfg});
        wr(ADDR_PROCESSOR_CONTROL, 8'h13);
        repeat (3) @(posedge i_ref_clk);
        #1 chk("run_wait", 8'h14, {1'b0, cfg});
        pulse_start();
        repeat (3) @(posedge i_ref_clk);
        #1 chk("run_on", 8'h54, {1'b0, cfg});
        wr(ADDR_PROCESSOR_CONTROL, 8'h17);
        repeat (3) @(posedge i_ref_clk);
        #1 chk("fs_hold", 8'h54, {1'b0, cfg});
        wr(ADDR_PROCESSOR_CONTROL, 8'h16);
        pulse_start();
        repeat (3) @(posedge i_ref_clk);
        #1 chk("fs_new", 8'h38, {1'b0, cfg});
        $display("test core run done");
        // Bank switching and state zeroing; no clear has happened before this point
        wr(ADDR_PROCESSOR_CONTROL, 8'ha4);
        repeat (4) @(posedge i_ref_clk);
        #1 chk("bank_b", {6'h0, BANK_B}, {6'h0, cfg.bank});
        wr(ADDR_PROCESSOR_CONTROL, 8'h84);
        repeat (4) @(posedge i_ref_clk);
        #1 chk("bank_a", {6'h0, BANK_A}, {6'h0, cfg.bank});
        chk("clears", 8'h02, 8'(n_clear));
        wr(ADDR_PROCESSOR_CONTROL, 8'h24);
        wr(ADDR_PROCESSOR_CONTROL, 8'h44);
        repeat (4) @(posedge i_ref_clk);
        #1 chk("bank_rsv", {6'h0, BANK_B}, {6'h0, cfg.bank});
        chk("no_clear", 8'h02, 8'(n_clear));
        rd_chk(ADDR_PROCESSOR_CONTROL);
        $display("test bank done");
        close_out();
    end
endmodule

// >>> verilog/clock_out_and_core_control.sv
`timescale 1ns/1ps

// Summary of operation
// - Output clock rate codes 000..100 give master clock times 2, times 1, and divided by 2, 4 and 8.
// - Rate code 111 stops the output clock and holds the pin low.
// - The two fastest selections do not work while density-modulated output is on, so the pin stays low.
// - The selected clock reaches the pin only while the pin is in clock output mode.
// - The LDO power-down bit at 1 powers the regulator down and at 0 keeps it active.
// - LDO voltage code 00 is 1.2 V and 01 is 1.1 V, other codes are reserved and ignored.
// - With the zero-state bit set, a switch of active bank clears the core data memory state.
// - Bank code 00 makes bank A active and 01 bank B, other codes are reserved and ignored.
// - Slow rate code 00, 01, 10 makes the slow rate equal to, a quarter or an eighth of the fast rate.
// - Sample rate codes 01, 10, 11 pick 96, 192 and 768 kHz, reset to 10, and 00 is reserved.
// - Sample rate and slow rate settings take effect only while the run bit is 0.
// - The run bit starts and stops the core, both at the beginning of the program.
module clock_out_and_core_control
    import output_clock_pin_core_pkg::*;
(
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_arst_n,
    input  wire logic                       i_clk_en,
    input  wire output_clock_pin_core_pkg::reg_req_t  i_req,
    output logic [7:0]                      o_rdata,
    input  wire logic                       i_master_clk,
    input  wire logic                       i_master_clk_x2,
    input  wire logic                       i_output_clock_pin_pin_mode,
    input  wire logic                       i_density_mod_enabled,
    input  wire logic                       i_program_start,
    output logic                            o_output_clock_pin,
    output logic                            o_ldo_power_down,
    output logic [1:0]                      o_ldo_voltage_sel,
    output output_clock_pin_core_pkg::core_cfg_t      o_core_cfg,
    output logic                            o_state_clear
);
    import output_clock_pin_core_pkg::*;

    typedef enum logic [0:0] {CORE_STOPPED, CORE_RUNNING} core_state_t;

    logic [7:0]  clock_output_select;
    logic [7:0]  ldo_control;
    logic [7:0]  processor_control;
    logic [2:0]  active_sel;
    logic [2:0]  div_cnt;
    logic        mclk_q;
    logic        next_pin;
    core_state_t core_state;

    wire logic [2:0] output_clock_rate_sel = clock_output_select[RATE_SEL_LSB +: 3];
    wire logic [1:0] reg_bank   = processor_control[BANK_SEL_LSB +: 2];
    wire logic [1:0] reg_fs     = processor_control[SAMPLE_RATE_LSB +: 2];
    wire logic [1:0] reg_slow   = processor_control[SLOW_RATE_LSB +: 2];
    wire logic       reg_run    = processor_control[RUN_BIT];
    wire logic       zero_state = processor_control[ZERO_STATE_BIT];
    wire logic       mclk_rise  = i_master_clk && !mclk_q;

    // Clock level produced by one selection code
    function automatic logic clk_of(input logic [2:0] sel, input logic x1, input logic x2,
                                    input logic [2:0] cnt);
        unique case (sel)
            CLK_SEL_X2:   clk_of = x2;
            CLK_SEL_X1:   clk_of = x1;
            CLK_SEL_DIV2: clk_of = cnt[0];
            CLK_SEL_DIV4: clk_of = cnt[1];
            CLK_SEL_DIV8: clk_of = cnt[2];
            default:      clk_of = 1'b0;
        endcase
    endfunction

    // Reserved codes of two-bit fields keep the previous value
    function automatic logic legal2(input logic [1:0] code, input logic [1:0] top);
        legal2 = (code <= top);
    endfunction

    // ==========================================================
    // Register writes and reads
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            clock_output_select <= RST_CLOCK_OUTPUT_SELECT;
            ldo_control         <= RST_LDO_CONTROL;
            processor_control   <= RST_PROCESSOR_CONTROL;
        end else if (i_clk_en && i_req.wr) begin
            unique case (i_req.addr)
                ADDR_CLOCK_OUTPUT_SELECT: clock_output_select <= i_req.wdata;
                ADDR_LDO_CONTROL:         ldo_control         <= i_req.wdata;
                ADDR_PROCESSOR_CONTROL:   processor_control   <= i_req.wdata;
                default: ;
            endcase
        end
    end

    // Read data is registered; unmapped reads answer zero
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= UNMAPPED_READ;
        end else if (i_clk_en && i_req.rd) begin
            unique case (i_req.addr)
                ADDR_CLOCK_OUTPUT_SELECT: o_rdata <= clock_output_select;
                ADDR_LDO_CONTROL:         o_rdata <= ldo_control;
                ADDR_PROCESSOR_CONTROL:   o_rdata <= processor_control;
                default:                  o_rdata <= UNMAPPED_READ;
            endcase
        end
    end

    // ==========================================================
    // Output clock divider, counted on master clock rising edges
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mclk_q  <= 1'b0;
            div_cnt <= 3'h0;
        end else if (i_clk_en) begin
            mclk_q <= i_master_clk;
            if (mclk_rise) begin
                div_cnt <= div_cnt + 3'h1;
            end
        end
    end

    // Switch selection only while both old and new clocks sit low, so no runt pulse leaves
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            active_sel <= RST_CLOCK_OUTPUT_SELECT[2:0];
        end else if (i_clk_en && active_sel != output_clock_rate_sel
                     && !o_output_clock_pin
                     && !clk_of(active_sel, i_master_clk, i_master_clk_x2, div_cnt)
                     && !clk_of(output_clock_rate_sel, i_master_clk, i_master_clk_x2, div_cnt)) begin
            active_sel <= output_clock_rate_sel;
        end
    end

    // Pin level: off code, foreign pin mode, or fast modes with density output give low
    always_comb begin
        next_pin = clk_of(active_sel, i_master_clk, i_master_clk_x2, div_cnt);
        if (!i_output_clock_pin_pin_mode) begin
            next_pin = 1'b0;
        end
        if (i_density_mod_enabled && (active_sel == CLK_SEL_X2 || active_sel == CLK_SEL_X1)) begin
            next_pin = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_output_clock_pin <= 1'b0;
        end else if (i_clk_en) begin
            o_output_clock_pin <= next_pin;
        end
    end

    // ==========================================================
    // Regulator controls; reserved voltage codes are not passed on
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_ldo_power_down  <= RST_LDO_CONTROL[LDO_PD_BIT];
            o_ldo_voltage_sel <= RST_LDO_CONTROL[1:0];
        end else if (i_clk_en) begin
            o_ldo_power_down <= ldo_control[LDO_PD_BIT];
            if (legal2(ldo_control[LDO_VSEL_LSB +: 2], LDO_V_1V1)) begin
                o_ldo_voltage_sel <= ldo_control[LDO_VSEL_LSB +: 2];
            end
        end
    end

    // ==========================================================
    // Core run state changes only at program start
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            core_state <= CORE_STOPPED;
        end else if (i_clk_en && i_program_start) begin
            core_state <= reg_run ? CORE_RUNNING : CORE_STOPPED;
        end
    end

    // Rates follow the register only once the run output has dropped, so a running program never sees a change;
    // the bank switch shares this process so the settings word has a single driver
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_core_cfg.run         <= 1'b0;
            o_core_cfg.sample_rate <= RST_PROCESSOR_CONTROL[SAMPLE_RATE_LSB +: 2];
            o_core_cfg.slow_rate   <= RST_PROCESSOR_CONTROL[SLOW_RATE_LSB +: 2];
            o_core_cfg.bank        <= BANK_A;
            o_state_clear          <= 1'b0;
        end else if (i_clk_en) begin
            o_core_cfg.run <= (core_state == CORE_RUNNING);
            o_state_clear  <= 1'b0;
            if (!reg_run && core_state == CORE_STOPPED && !o_core_cfg.run) begin
                if (reg_fs != FS_RESERVED) begin
                    o_core_cfg.sample_rate <= reg_fs;
                end
                if (legal2(reg_slow, SLOW_DIV8)) begin
                    o_core_cfg.slow_rate <= reg_slow;
                end
            end
            // Bank switch, with a one-cycle state clear when zeroing is enabled
            if (legal2(reg_bank, BANK_B) && reg_bank != o_core_cfg.bank) begin
                o_core_cfg.bank <= reg_bank;
                o_state_clear   <= zero_state;
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);

    sequence s_bank_change;
        i_clk_en && legal2(reg_bank, BANK_B) && reg_bank != o_core_cfg.bank;
    endsequence

    a_off_holds_low: assert property (i_clk_en && active_sel == CLK_SEL_OFF |=> !o_output_clock_pin)
        else $error("pin not low with output clock off");
    a_pin_mode_gate: assert property (i_clk_en && !i_output_clock_pin_pin_mode |=> !o_output_clock_pin)
        else $error("pin driven outside clock output mode");
    a_fast_with_pdm: assert property (i_clk_en && i_density_mod_enabled && active_sel <= CLK_SEL_X1
                                      |=> !o_output_clock_pin)
        else $error("fast output clock while density output enabled");
    a_div2_follows: assert property (i_clk_en && i_output_clock_pin_pin_mode && active_sel == CLK_SEL_DIV2
                                     |=> o_output_clock_pin == $past(div_cnt[0]))
        else $error("divide by two output wrong");
    a_switch_low: assert property (i_clk_en && $changed(active_sel) |-> !$past(o_output_clock_pin))
        else $error("selection switched while pin high");
    a_ldo_pd_follow: assert property (i_clk_en |=> o_ldo_power_down == $past(ldo_control[LDO_PD_BIT]))
        else $error("power down output does not follow register");
    a_ldo_v_legal: assert property (o_ldo_voltage_sel <= LDO_V_1V1)
        else $error("reserved regulator voltage driven");
    a_rate_frozen: assert property (o_core_cfg.run |=> $stable(o_core_cfg.sample_rate)
                                    && $stable(o_core_cfg.slow_rate))
        else $error("rate changed while core running");
    a_fs_legal: assert property (o_core_cfg.sample_rate != FS_RESERVED)
        else $error("reserved sample rate applied");
    a_run_at_start: assert property (i_clk_en && !i_program_start ##1 i_clk_en |=> $stable(o_core_cfg.run))
        else $error("run changed away from program start");
    a_zero_clear: assert property (s_bank_change |=> o_state_clear == $past(zero_state))
        else $error("state clear wrong on bank switch");
    a_bank_apply: assert property (s_bank_change |=> o_core_cfg.bank == $past(reg_bank))
        else $error("bank not applied on switch");
    // A clear may only follow an enabled cycle that switched the bank, so it never stretches
    a_clear_once: assert property (i_clk_en && !(legal2(reg_bank, BANK_B) && reg_bank != o_core_cfg.bank)
                                   |=> !o_state_clear)
        else $error("state clear without bank switch");

endmodule
